/* bench/csfm_clock_switch_chk.sv */
// port assertions for the clock switch
`timescale 1ns/10ps
module csfm_clock_switch_chk
  import csfm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // oscillators and sleep
  input wire csfm_ready_s osc_ready_i,
  input wire logic sleep_i,
  input wire logic wake_i,
  input wire csfm_sel_s sys_sel_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  logic [1:0] live_r;
  logic setup;
  assign setup = psel_i && !penable_i;
  // settles after the straps load
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      live_r <= 2'h0;
    else if (live_r != 2'h3)
      live_r <= live_r + 2'h1;
  end
  ready_after_setup_a: assert property (setup |=> pready_o)
    else $error("no ready after setup");
  ready_cause_a: assert property (pready_o |-> $past(setup))
    else $error("ready without setup");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (setup && paddr_i > 12'h010 |=> pslverr_o && prdata_o == 32'h0)
    else $error("unmapped access not refused");
  mapped_ok_a: assert property (setup && paddr_i <= 12'h010 |=> !pslverr_o)
    else $error("mapped access refused");
  div_range_a: assert property (sys_sel_o.div <= 4'h9)
    else $error("reserved divider active");
  ext_ready_a: assert property (live_r == 2'h3 && sys_sel_o.src == 3'h7 && $changed(sys_sel_o.src) |-> $past(osc_ready_i.ext))
    else $error("switched to external before ready");
  slow_ready_a: assert property (live_r == 2'h3 && sys_sel_o.src == 3'h5 && $changed(sys_sel_o.src) |-> $past(osc_ready_i.lfint))
    else $error("switched to slow internal before ready");
  sec_ready_a: assert property (live_r == 2'h3 && sys_sel_o.src == 3'h4 && $changed(sys_sel_o.src) |-> $past(osc_ready_i.sec))
    else $error("switched to secondary before ready");
  sleep_freeze_a: assert property (sleep_i [*3] ##0 !wake_i |-> $stable(sys_sel_o))
    else $error("selection changed in sleep");
  cover property ($changed(sys_sel_o) && sys_sel_o == 7'h60);
  cover property ($changed(sys_sel_o) && sys_sel_o.src == 3'h4);
  cover property (setup && paddr_i > 12'h010);
endmodule
bind csfm_clock_switch csfm_clock_switch_chk chk_u (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i),
  .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .osc_ready_i(osc_ready_i), .sleep_i(sleep_i), .wake_i(wake_i),
  .sys_sel_o(sys_sel_o));

/* bench/tb_top.sv */
// self-checking bench for the clock switch
`timescale 1ns/10ps
module tb_top;
  import csfm_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [11:0] pa = 12'h0;
  logic [31:0] pwd = 32'h0;
  logic [31:0] prd;
  logic prdy;
  logic perr;
  logic [31:0] q;
  // ext, hf, lf and pll ready; secondary off
  csfm_ready_s rdy = 5'h1D;
  logic xclk = 1'b0;
  logic lclk = 1'b0;
  logic xrun = 1'b1;
  logic slp = 1'b0;
  logic wk = 1'b0;
  logic slow = 1'b0;
  logic pfail = 1'b0;
  logic xtal = 1'b0;
  csfm_sel_s sel;
  logic irq;
  logic stall;
  logic [4:0] en;
  int fails = 0;
  int checked = 0;
  int cyc = 0;
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    lclk <= ~lclk;
    xclk <= xrun ? ~xclk : 1'b0;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      summarize();
    end
  end
  csfm_clock_switch dut_u (.clk_sys_i(clk), .sys_rst_i(rst), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(pa), .pwdata_i(pwd), .prdata_o(prd), .pready_o(prdy), .pslverr_o(perr),
    .reset_source_config_i(3'h6), .ext_is_crystal_i(xtal), .osc_ready_i(rdy), .ext_clk_i(xclk),
    .lf_clk_i(lclk), .osc_edge_i(xclk), .pll_lock_fail_i(pfail), .sleep_i(slp), .wake_i(wk),
    .reduced_core_rate_i(slow), .sys_sel_o(sel), .source_enable_o(en), .clock_stall_o(stall), .irq_o(irq));
  task automatic summarize();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
      @(posedge clk);
    while (prdy !== 1'b1);
    r = prd;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, q);
    chk(nm, e, q);
  endtask
  task automatic wsel(input logic [6:0] e, input int lim);
    int n;
    n = 0;
    while (sel !== e && n < lim)
    begin
      @(posedge clk);
      n++;
    end
    chk("sel", {25'h0, e}, {25'h0, sel});
  endtask
  task automatic t_reset();
    rd("config", 12'h010, 32'h1);
    rd("request", 12'h000, 32'h62);
    rd("current", 12'h004, 32'h62);
    wr(12'h010, 32'h0);
    wr(12'h000, 32'h50);
    rd("request", 12'h000, 32'h62);
    wr(12'h010, 32'h1);
    rd("unmapped", 12'h020, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_switch();
    wr(12'h00C, 32'h4);
    wr(12'h000, 32'h50);
    wsel(7'h50, 50);
    rd("flags", 12'h00C, 32'h5);
    chk("irq", 32'h1, irq);
    rd("control", 12'h008, 32'h10);
    rd("current", 12'h004, 32'h50);
    wr(12'h00C, 32'h0);
    rd("flags", 12'h00C, 32'h0);
    chk("irq", 32'h0, irq);
    $display("test switch done");
  endtask
  task automatic t_codes();
    wr(12'h000, 32'h30);
    rd("request", 12'h000, 32'h50);
    wr(12'h000, 32'h03);
    rd("request", 12'h000, 32'h50);
    wr(12'h000, 32'h5A);
    rd("request", 12'h000, 32'h50);
    for (int d = 9; d >= 0; d--)
    begin
      wr(12'h000, 32'h50 + d);
      wsel(7'h50 + d[6:0], 50);
    end
    $display("test codes done");
  endtask
  task automatic t_hold();
    wr(12'h008, 32'h80);
    wr(12'h000, 32'h40);
    repeat (20) @(posedge clk);
    chk("sel", 32'h50, sel);
    rdy.sec <= 1'b1;
    repeat (20) @(posedge clk);
    chk("sel", 32'h50, sel);
    rd("control", 12'h008, 32'h88);
    rd("current", 12'h004, 32'h50);
    wr(12'h008, 32'h0);
    wsel(7'h40, 50);
    rd("control", 12'h008, 32'h10);
    $display("test hold done");
  endtask
  task automatic t_fail();
    wr(12'h010, 32'h3);
    wr(12'h000, 32'h70);
    wsel(7'h70, 50);
    wr(12'h00C, 32'h0);
    xrun <= 1'b0;
    wsel(7'h60, 1000);
    apb(1'b0, 12'h00C, 32'h0, q);
    chk("fail flag", 32'h1, q[1]);
    xrun <= 1'b1;
    wr(12'h00C, 32'h0);
    wr(12'h000, 32'h70);
    wsel(7'h70, 50);
    $display("test failsafe done");
  endtask
  task automatic t_sleep();
    rdy.sec <= 1'b0;
    wr(12'h00C, 32'h0);
    wr(12'h000, 32'h40);
    slp <= 1'b1;
    repeat (10) @(posedge clk);
    rdy.sec <= 1'b1;
    repeat (10) @(posedge clk);
    chk("sel", 32'h70, sel);
    slp <= 1'b0;
    wk <= 1'b1;
    @(posedge clk);
    wk <= 1'b0;
    wsel(7'h40, 50);
    rd("flags", 12'h00C, 32'h1);
    $display("test sleep done");
  endtask
  task automatic t_pll();
    int n;
    n = 0;
    slow <= 1'b1;
    wr(12'h000, 32'h10);
    wsel(7'h10, 50);
    slow <= 1'b0;
    wr(12'h000, 32'h20);
    while (stall !== 1'b1 && n < 50)
    begin
      @(posedge clk);
      n++;
    end
    chk("stall", 32'h1, stall);
    chk("enable", 32'h19, en);
    wsel(7'h20, 50);
    chk("enable", 32'h11, en);
    chk("stall", 32'h0, stall);
    pfail <= 1'b1;
    wsel(7'h60, 20);
    rd("flags", 12'h00C, 32'h3);
    pfail <= 1'b0;
    wr(12'h00C, 32'h1);
    rd("flags", 12'h00C, 32'h1);
    wr(12'h000, 32'h20);
    wsel(7'h20, 20);
    xtal <= 1'b1;
    wr(12'h000, 32'h70);
    repeat (1000) @(posedge clk);
    chk("sel", 32'h20, sel);
    wsel(7'h70, 1500);
    xtal <= 1'b0;
    $display("test pll done");
  endtask
  initial
  begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_switch();
    t_codes();
    t_hold();
    t_fail();
    t_sleep();
    t_pll();
    summarize();
  end
endmodule

/* verilog/csfm_clock_switch.sv */
// clock source switch with post-divider and fail-safe external clock monitor
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/10ps
`include "csfm_map.svh"
module csfm_clock_switch
  import csfm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // configuration straps
  input wire logic [2:0] reset_source_config_i,
  input wire logic ext_is_crystal_i,
  // oscillator side, sampled levels
  input wire csfm_ready_s osc_ready_i,
  input wire logic ext_clk_i,
  input wire logic lf_clk_i,
  input wire logic osc_edge_i,
  input wire logic pll_lock_fail_i,
  // sleep controller
  input wire logic sleep_i,
  input wire logic wake_i,
  input wire logic reduced_core_rate_i,
  // clock selection out
  output csfm_sel_s sys_sel_o,
  output logic [4:0] source_enable_o,
  output logic clock_stall_o,
  output logic irq_o
);
  csfm_state_e state_r;
  csfm_sel_s req_r;
  csfm_sel_s cur_r;
  logic hold_r, newrdy_r, done_r, allow_r, fs_en_r, failsafe_r;
  logic sw_flag_r, fail_flag_r, sw_en_r, fail_en_r;
  logic [31:0] prdata_r;
  logic pready_r, pslverr_r;
  logic [5:0] lf_div_r;
  logic lf_q_r, ext_q_r, samp_r, samp_prev_r, latch_r;
  logic [10:0] stup_cnt_r;
  logic stup_done_r;
  logic asleep_r, init_r;
  logic [31:0] rd_nxt;
  logic apb_wr, apb_rd, req_wr_ok, pending, ready_now, pll_change, mon_active, fail_evt;

  // reserved codes run as the high-frequency internal oscillator
  function automatic logic [2:0] eff_src(input logic [2:0] s);
    eff_src = (s == `CSFM_SRC_RSV3 || s == `CSFM_SRC_RSV0) ? `CSFM_SRC_HFINT : s;
  endfunction
  // oscillators that a selection runs on, in ready-struct order
  function automatic logic [4:0] src_bits(input logic [2:0] s);
    case (eff_src(s))
      `CSFM_SRC_EXT: src_bits = 5'h10;
      `CSFM_SRC_LFINT: src_bits = 5'h04;
      `CSFM_SRC_SEC: src_bits = 5'h02;
      `CSFM_SRC_EXT_PLL: src_bits = 5'h11;
      `CSFM_SRC_HF_PLL: src_bits = 5'h09;
      default: src_bits = 5'h08;
    endcase
  endfunction
  // every oscillator used is ready; external waits for the startup timer too
  function automatic logic src_ready(input logic [2:0] s, input csfm_ready_s r, input logic od);
    src_ready = ((src_bits(s) & ~r) == 5'h00) && (od || (src_bits(s) & 5'h10) == 5'h00);
  endfunction
  function automatic logic is_ext(input logic [2:0] s);
    is_ext = (s == `CSFM_SRC_EXT || s == `CSFM_SRC_EXT_PLL || s == `CSFM_SRC_SEC);
  endfunction
  function automatic logic is_pll(input logic [2:0] s);
    is_pll = (s == `CSFM_SRC_EXT_PLL || s == `CSFM_SRC_HF_PLL);
  endfunction
  function automatic logic [3:0] rst_div(input logic [2:0] s);
    rst_div = (s == `CSFM_SRC_HFINT) ? `CSFM_DIV_RST_HF : `CSFM_DIV_RST_OTHER;
  endfunction

  csfm_sel_s wr_sel;
  assign apb_wr = psel_i && penable_i && pwrite_i;
  assign apb_rd = psel_i && penable_i && !pwrite_i;
  assign wr_sel.src = pwdata_i[`CSFM_SRC_LSB+2:`CSFM_SRC_LSB];
  assign wr_sel.div = pwdata_i[3:0];
  assign req_wr_ok = apb_wr && paddr_i == `CSFM_OFS_REQUEST && allow_r
    && wr_sel.src != `CSFM_SRC_RSV3 && wr_sel.src != `CSFM_SRC_RSV0
    && wr_sel.div <= `CSFM_DIV_MAX;
  assign pending = req_r != cur_r;
  // same source counts as running, so a divider-only change waits for hold alone
  assign ready_now = (eff_src(req_r.src) == eff_src(cur_r.src))
    || src_ready(req_r.src, osc_ready_i, stup_done_r);
  assign pll_change = is_pll(req_r.src) && is_pll(cur_r.src) && req_r.src != cur_r.src;

  // register file: one-cycle apb answer
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    case (paddr_i)
      `CSFM_OFS_REQUEST: rd_nxt = {25'h0, req_r.src, req_r.div};
      `CSFM_OFS_CURRENT: rd_nxt = {25'h0, cur_r.src, cur_r.div};
      `CSFM_OFS_CONTROL: rd_nxt = {24'h0, hold_r, 2'h0, done_r, newrdy_r, 3'h0};
      `CSFM_OFS_FLAGS: rd_nxt = {28'h0, fail_en_r, sw_en_r, fail_flag_r, sw_flag_r};
      `CSFM_OFS_CONFIG: rd_nxt = {30'h0, fs_en_r, allow_r};
      default: rd_nxt = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      prdata_r <= 32'h0000_0000;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end
    else
    begin
      pready_r <= psel_i && !penable_i;
      pslverr_r <= psel_i && !penable_i && paddr_i > `CSFM_OFS_CONFIG;
      if (apb_rd || (psel_i && !penable_i))
        prdata_r <= rd_nxt;
    end
  end

  // configuration, enables and hold bit
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      allow_r <= 1'b1;
      fs_en_r <= 1'b0;
      sw_en_r <= 1'b0;
      fail_en_r <= 1'b0;
      hold_r <= 1'b0;
    end
    else if (apb_wr && pready_r)
    begin
      if (paddr_i == `CSFM_OFS_CONFIG)
      begin
        allow_r <= pwdata_i[`CSFM_CFG_SWITCH_ALLOW];
        fs_en_r <= pwdata_i[`CSFM_CFG_FAILSAFE_EN];
      end
      if (paddr_i == `CSFM_OFS_FLAGS)
      begin
        sw_en_r <= pwdata_i[`CSFM_FLG_SWITCH_EN];
        fail_en_r <= pwdata_i[`CSFM_FLG_FAIL_EN];
      end
      if (paddr_i == `CSFM_OFS_CONTROL)
        hold_r <= pwdata_i[`CSFM_CTL_HOLD];
    end
  end

  // high in the first cycle after reset release: straps load then
  always_ff @(posedge clk_sys_i)
    init_r <= sys_rst_i;

  // request register
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
      req_r <= '0;
    else if (init_r)
    begin
      req_r.src <= reset_source_config_i;
      req_r.div <= rst_div(reset_source_config_i);
    end
    else if (req_wr_ok && pready_r)
      req_r <= wr_sel;
  end

  // switch sequencer
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      state_r <= CSFM_IDLE;
      cur_r <= '0;
      newrdy_r <= 1'b0;
      done_r <= 1'b1;
      sw_flag_r <= 1'b0;
      asleep_r <= 1'b0;
    end
    else if (init_r)
    begin
      cur_r.src <= reset_source_config_i;
      cur_r.div <= rst_div(reset_source_config_i);
    end
    else
    begin
      if (apb_wr && pready_r && paddr_i == `CSFM_OFS_FLAGS && !pwdata_i[`CSFM_FLG_SWITCH])
        sw_flag_r <= 1'b0;
      if (sleep_i)
      begin
        asleep_r <= 1'b1;
        state_r <= CSFM_IDLE;
        newrdy_r <= 1'b0;
      end
      else if (asleep_r)
      begin
        if (wake_i)
        begin
          asleep_r <= 1'b0;
          if (pending && !hold_r)
          begin
            cur_r <= req_r;
            sw_flag_r <= 1'b1;
          end
        end
      end
      else
        case (state_r)
          CSFM_IDLE:
          begin
            done_r <= !pending;
            if (pending)
              state_r <= CSFM_WAIT;
          end
          CSFM_WAIT:
          begin
            if (!pending)
            begin
              state_r <= CSFM_IDLE;
              newrdy_r <= 1'b0;
              done_r <= 1'b1;
            end
            else if (ready_now)
            begin
              newrdy_r <= 1'b1;
              sw_flag_r <= 1'b1;
              state_r <= CSFM_HOLD;
            end
          end
          CSFM_HOLD:
          begin
            // next system cycle regardless of core rate
            if (!pending)
            begin
              state_r <= CSFM_IDLE;
              newrdy_r <= 1'b0;
              done_r <= 1'b1;
            end
            else if (!hold_r || (reduced_core_rate_i && !hold_r))
            begin
              if (pll_change)
                state_r <= CSFM_RELOCK;
              else
              begin
                cur_r <= req_r;
                newrdy_r <= 1'b0;
                done_r <= 1'b1;
                state_r <= CSFM_IDLE;
              end
            end
          end
          CSFM_RELOCK:
          begin
            if (osc_ready_i.pll || pll_lock_fail_i)
            begin
              cur_r <= req_r;
              newrdy_r <= 1'b0;
              done_r <= 1'b1;
              state_r <= CSFM_IDLE;
            end
          end
          default: state_r <= CSFM_IDLE;
        endcase
    end
  end

  // startup timer counts oscillator edges for crystal modes
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || sleep_i || (req_wr_ok && pready_r && is_ext(wr_sel.src)))
    begin
      stup_cnt_r <= 11'd0;
      stup_done_r <= 1'b0;
    end
    else if (!ext_is_crystal_i)
      stup_done_r <= 1'b1;
    else if (osc_edge_i && !stup_done_r)
    begin
      stup_cnt_r <= stup_cnt_r + 11'd1;
      stup_done_r <= (stup_cnt_r + 11'd1) == `CSFM_STARTUP_CYCLES;
    end
  end

  // monitor sample clock and detector latch
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      lf_q_r <= 1'b0;
      ext_q_r <= 1'b0;
      lf_div_r <= 6'd0;
      samp_r <= 1'b0;
      samp_prev_r <= 1'b0;
      latch_r <= 1'b0;
    end
    else
    begin
      lf_q_r <= lf_clk_i;
      ext_q_r <= ext_clk_i;
      if (lf_clk_i && !lf_q_r)
      begin
        lf_div_r <= lf_div_r + 6'd1;
        if (lf_div_r == 6'd31 || lf_div_r == 6'd63)
          samp_r <= !samp_r;
      end
      samp_prev_r <= samp_r;
      if (ext_q_r && !ext_clk_i)
        latch_r <= 1'b1;
      else if (samp_r && !samp_prev_r)
        latch_r <= 1'b0;
    end
  end

  assign mon_active = fs_en_r && is_ext(eff_src(cur_r.src)) && stup_done_r && !asleep_r;
  // latch still clear at the falling sample edge means a silent half-period
  assign fail_evt = fs_en_r && ((mon_active && !samp_r && samp_prev_r && !latch_r)
    || (pll_lock_fail_i && is_pll(cur_r.src)));

  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      failsafe_r <= 1'b0;
      fail_flag_r <= 1'b0;
    end
    else
    begin
      if (fail_evt)
        failsafe_r <= 1'b1;
      else if (sleep_i || (req_wr_ok && pready_r))
        failsafe_r <= 1'b0;
      if (fail_evt)
        fail_flag_r <= 1'b1;
      else if (apb_wr && pready_r && paddr_i == `CSFM_OFS_FLAGS && !pwdata_i[`CSFM_FLG_FAIL])
        fail_flag_r <= 1'b0;
    end
  end

  // outputs
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      sys_sel_o <= '0;
      source_enable_o <= 5'h00;
      clock_stall_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      sys_sel_o <= failsafe_r ? csfm_sel_s'{`CSFM_SRC_HFINT, `CSFM_FAIL_DIV}
        : csfm_sel_s'{eff_src(cur_r.src), cur_r.div};
      source_enable_o <= src_bits(req_r.src) | src_bits(cur_r.src);
      clock_stall_o <= state_r == CSFM_RELOCK;
      irq_o <= (sw_flag_r && sw_en_r) || (fail_flag_r && fail_en_r);
    end
  end

  assign prdata_o = prdata_r;
  assign pready_o = pready_r;
  assign pslverr_o = pslverr_r;
endmodule

/* verilog/csfm_map.svh */
// register offsets, field positions, reset values and timing counts
`ifndef CSFM_MAP_SVH
`define CSFM_MAP_SVH
`define CSFM_OFS_REQUEST 12'h000
`define CSFM_OFS_CURRENT 12'h004
`define CSFM_OFS_CONTROL 12'h008
`define CSFM_OFS_FLAGS 12'h00C
`define CSFM_OFS_CONFIG 12'h010
`define CSFM_SRC_LSB 4
`define CSFM_CTL_HOLD 7
`define CSFM_CTL_DONE 4
`define CSFM_CTL_NEWRDY 3
`define CSFM_FLG_SWITCH 0
`define CSFM_FLG_FAIL 1
`define CSFM_FLG_SWITCH_EN 2
`define CSFM_FLG_FAIL_EN 3
`define CSFM_CFG_SWITCH_ALLOW 0
`define CSFM_CFG_FAILSAFE_EN 1
`define CSFM_SRC_EXT 3'h7
`define CSFM_SRC_HFINT 3'h6
`define CSFM_SRC_LFINT 3'h5
`define CSFM_SRC_SEC 3'h4
`define CSFM_SRC_RSV3 3'h3
`define CSFM_SRC_EXT_PLL 3'h2
`define CSFM_SRC_HF_PLL 3'h1
`define CSFM_SRC_RSV0 3'h0
`define CSFM_DIV_RST_HF 4'h2
`define CSFM_DIV_RST_OTHER 4'h0
`define CSFM_DIV_MAX 4'h9
`define CSFM_FAIL_DIV 4'h0
`define CSFM_SAMPLE_DIV 7'd64
`define CSFM_STARTUP_CYCLES 11'd1024
`endif

/* verilog/csfm_pkg.sv */
// types of the clock switch and fail-safe monitor
package csfm_pkg;
  typedef struct packed {
    logic ext;
    logic hfint;
    logic lfint;
    logic sec;
    logic pll;
  } csfm_ready_s;
  typedef struct packed {
    logic [2:0] src;
    logic [3:0] div;
  } csfm_sel_s;
  typedef enum logic [3:0] {
    CSFM_IDLE = 4'b0001,
    CSFM_WAIT = 4'b0010,
    CSFM_HOLD = 4'b0100,
    CSFM_RELOCK = 4'b1000
  } csfm_state_e;
endpackage
